/* pll_filter_cal_nvm_status_regs.sv */
`timescale 1ns/10ps
// Behaviour
// - read/write 7-bit third-resistor code in bits 6:0, resets zero, reloadable from memory.
// - third-resistor code maps to ohms: 0->18, 3->205 up to 0x14->2335.
// - read/write 3-bit third-capacitor code, resets zero, five picofarads per step.
// - closed-loop wait select bits 3:2 pick 150/300/500/2000 us, resets to 2.
// - oscillator wait select bits 1:0 pick 20/400/4000/10000 us, resets to 1.
// - read-only stored checksum byte, zero until fetched from memory.
// - program count increments after each erase/program cycle and is saved back.
// - program count reloads from memory on each fetch; a fetch wins over a cycle-done step in the same cycle.
// - program count saturates at 255; later cycles leave it unchanged.
// - cycle starts only if previous transaction wrote the correct unlock code.
module pll_filter_cal_nvm_status_regs #(
  parameter int VCO_WAIT2_CYC = pll_cal_regs_pkg::VCO_WAIT2_US * pll_cal_regs_pkg::CLK_MHZ,
  parameter int VCO_WAIT3_CYC = pll_cal_regs_pkg::VCO_WAIT3_US * pll_cal_regs_pkg::CLK_MHZ,
  parameter int CL_WAIT2_CYC = pll_cal_regs_pkg::CL_WAIT2_US * pll_cal_regs_pkg::CLK_MHZ,
  parameter int CL_WAIT3_CYC = pll_cal_regs_pkg::CL_WAIT3_US * pll_cal_regs_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port from the serial interface engine
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // values fetched from non-volatile memory
  input wire logic nvm_load,
  input wire logic [6:0] nvm_res_code,
  input wire logic [2:0] nvm_cap_code,
  input wire logic [3:0] nvm_cal_wait,
  input wire logic [7:0] nvm_checksum,
  input wire logic [7:0] nvm_count,
  // erase/program handshake
  output logic nvm_cycle_start,
  output logic nvm_erase_req,
  output logic nvm_prog_req,
  input wire logic nvm_cycle_done,
  output logic [7:0] nvm_count_save,
  output logic nvm_count_save_en,
  // calibration sequencing
  input wire logic cal_start,
  output logic vco_settling,
  output logic loop_settling,
  output logic cal_done,
  // loop filter and wait settings
  output logic [6:0] filter_res_three_code,
  output logic [11:0] filter_res_ohms,
  output logic [2:0] filter_cap_three_code,
  output logic [5:0] filter_cap_pf,
  output logic [1:0] closed_loop_settle_select,
  output logic [1:0] oscillator_settle_select
);
  generate
    if (VCO_WAIT2_CYC < 1 || VCO_WAIT3_CYC < 1 || CL_WAIT2_CYC < 1 || CL_WAIT3_CYC < 1 ||
        VCO_WAIT2_CYC > 131072 || VCO_WAIT3_CYC > 131072 ||
        CL_WAIT2_CYC > 131072 || CL_WAIT3_CYC > 131072) begin : g_bad_wait
      $error("settling counts must lie in 1..131072");
    end
  endgenerate

  typedef struct packed {
    logic [6:0] res;
    logic [11:0] ohms;
    logic [2:0] cap;
    logic [5:0] cap_pf;
    logic [1:0] cl_sel;
    logic [1:0] vco_sel;
    logic [7:0] checksum;
    logic [7:0] count;
    logic unlocked;
    logic busy;
    logic start;
    logic erase;
    logic prog;
    logic [7:0] save;
    logic save_en;
    logic [7:0] rd_data;
    logic rd_valid;
  } regs_t;

  regs_t st;
  regs_t next_st;
  logic wr_res;
  logic wr_cap;
  logic wr_cal;
  logic wr_ctrl;
  logic go;
  logic [7:0] bumped;

  assign wr_res = reg_wr_en && reg_addr == pll_cal_regs_pkg::RES_THREE_OFFSET;
  assign wr_cap = reg_wr_en && reg_addr == pll_cal_regs_pkg::CAP_THREE_OFFSET;
  assign wr_cal = reg_wr_en && reg_addr == pll_cal_regs_pkg::CAL_WAIT_OFFSET;
  assign wr_ctrl = reg_wr_en && reg_addr == pll_cal_regs_pkg::NVM_CONTROL_OFFSET;
  // a second request while busy is dropped, the array cannot take it
  assign go = wr_ctrl && st.unlocked && !st.busy &&
              (reg_wr_data[pll_cal_regs_pkg::ERASE_BIT] ||
               reg_wr_data[pll_cal_regs_pkg::PROG_BIT]);
  assign bumped = (st.count == pll_cal_regs_pkg::COUNT_MAX) ?
                  st.count : st.count + 8'h01;

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.save_en = 1'b0;
    next_st.rd_valid = reg_rd_en;
    if (wr_res) begin
      next_st.res = reg_wr_data[6:0];
    end
    if (wr_cap) begin
      next_st.cap = reg_wr_data[2:0];
    end
    if (wr_cal) begin
      next_st.cl_sel = reg_wr_data[pll_cal_regs_pkg::CL_SEL_LSB +: 2];
      next_st.vco_sel = reg_wr_data[pll_cal_regs_pkg::VCO_SEL_LSB +: 2];
    end
    // any access after the unlock write spends it
    if (reg_wr_en || reg_rd_en) begin
      next_st.unlocked = reg_wr_en && reg_addr == pll_cal_regs_pkg::UNLOCK_OFFSET &&
                         reg_wr_data == pll_cal_regs_pkg::UNLOCK_CODE;
    end
    if (go) begin
      next_st.start = 1'b1;
      next_st.busy = 1'b1;
      next_st.erase = reg_wr_data[pll_cal_regs_pkg::ERASE_BIT];
      next_st.prog = reg_wr_data[pll_cal_regs_pkg::PROG_BIT];
    end else if (nvm_cycle_done) begin
      next_st.busy = 1'b0;
    end
    if (nvm_cycle_done) begin
      next_st.count = bumped;
      next_st.save = bumped;
      next_st.save_en = 1'b1;
    end
    // a fetch from memory overrides register writes in the same cycle
    if (nvm_load) begin
      next_st.res = nvm_res_code;
      next_st.cap = nvm_cap_code;
      next_st.cl_sel = nvm_cal_wait[pll_cal_regs_pkg::CL_SEL_LSB +: 2];
      next_st.vco_sel = nvm_cal_wait[pll_cal_regs_pkg::VCO_SEL_LSB +: 2];
      next_st.checksum = nvm_checksum;
      next_st.count = nvm_count;
    end
    next_st.ohms = pll_cal_regs_pkg::res_ohms(next_st.res);
    next_st.cap_pf = 6'(next_st.cap * pll_cal_regs_pkg::CAP_PF_STEP);
    case (reg_addr)
      pll_cal_regs_pkg::RES_THREE_OFFSET: next_st.rd_data = {1'b0, st.res};
      pll_cal_regs_pkg::CAP_THREE_OFFSET: next_st.rd_data = {5'h00, st.cap};
      pll_cal_regs_pkg::CAL_WAIT_OFFSET: next_st.rd_data = {4'h0, st.cl_sel, st.vco_sel};
      pll_cal_regs_pkg::CHECKSUM_OFFSET: next_st.rd_data = st.checksum;
      pll_cal_regs_pkg::PROG_COUNT_OFFSET: next_st.rd_data = st.count;
      pll_cal_regs_pkg::NVM_CONTROL_OFFSET: next_st.rd_data = {5'h00, st.busy, 2'h0};
      default: next_st.rd_data = pll_cal_regs_pkg::READ_ZERO;
    endcase
    if (!reg_rd_en) begin
      next_st.rd_data = pll_cal_regs_pkg::READ_ZERO;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{res: pll_cal_regs_pkg::RES_RESET, ohms: 12'h012,
              cap: pll_cal_regs_pkg::CAP_RESET, cap_pf: 6'h00,
              cl_sel: pll_cal_regs_pkg::CL_SEL_RESET,
              vco_sel: pll_cal_regs_pkg::VCO_SEL_RESET,
              checksum: pll_cal_regs_pkg::CHECKSUM_RESET,
              count: pll_cal_regs_pkg::COUNT_RESET,
              unlocked: 1'b0, busy: 1'b0, start: 1'b0, erase: 1'b0, prog: 1'b0,
              save: 8'h00, save_en: 1'b0, rd_data: 8'h00, rd_valid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign filter_res_three_code = st.res;
  assign filter_res_ohms = st.ohms;
  assign filter_cap_three_code = st.cap;
  assign filter_cap_pf = st.cap_pf;
  assign closed_loop_settle_select = st.cl_sel;
  assign oscillator_settle_select = st.vco_sel;
  assign nvm_cycle_start = st.start;
  assign nvm_erase_req = st.erase;
  assign nvm_prog_req = st.prog;
  assign nvm_count_save = st.save;
  assign nvm_count_save_en = st.save_en;
  assign reg_rd_data = st.rd_data;
  assign reg_rd_valid = st.rd_valid;

  settle_timer #(
    .VCO_WAIT2_CYC(VCO_WAIT2_CYC),
    .VCO_WAIT3_CYC(VCO_WAIT3_CYC),
    .CL_WAIT2_CYC(CL_WAIT2_CYC),
    .CL_WAIT3_CYC(CL_WAIT3_CYC)
  ) u_settle (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cal_start(cal_start),
    .vco_sel(st.vco_sel),
    .cl_sel(st.cl_sel),
    .vco_settling(vco_settling),
    .loop_settling(loop_settling),
    .cal_done(cal_done)
  );

  chk_count_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (nvm_cycle_done && !nvm_load && st.count != 8'hFF) |=>
      (st.count == $past(st.count) + 8'h01 && nvm_count_save_en && nvm_count_save == st.count))
    else $error("program count did not step by one");

  chk_count_saturate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (nvm_cycle_done && !nvm_load && st.count == 8'hFF) |=> st.count == 8'hFF)
    else $error("program count left 255");

  chk_count_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nvm_load |=> (st.count == $past(nvm_count) && st.checksum == $past(nvm_checksum)))
    else $error("fetch did not reload count and checksum");

  chk_unlock_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nvm_cycle_start |-> $past(st.unlocked && wr_ctrl))
    else $error("cycle started without unlock");

  chk_res_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (filter_res_three_code == 7'h14) |-> filter_res_ohms == 12'h91F)
    else $error("code 0x14 not mapped to 2335 ohms");

  chk_cap_scale: assert property (@(posedge sys_clk) disable iff (sys_rst)
    filter_cap_pf == 6'(filter_cap_three_code * 3'h5))
    else $error("capacitance not five pF per step");

  chk_res_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_res && !nvm_load) |=> ##1 (reg_rd_en && reg_addr == 8'h26) |=>
      reg_rd_data == {1'b0, $past(filter_res_three_code)})
    else $error("resistor code readback wrong");

endmodule // pll_filter_cal_nvm_status_regs

/* pll_cal_regs_pkg.sv */
package pll_cal_regs_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] RES_THREE_OFFSET = 8'h26;
  localparam logic [7:0] CAP_THREE_OFFSET = 8'h27;
  localparam logic [7:0] CAL_WAIT_OFFSET = 8'h2A;
  localparam logic [7:0] CHECKSUM_OFFSET = 8'h2F;
  localparam logic [7:0] PROG_COUNT_OFFSET = 8'h30;
  localparam logic [7:0] NVM_CONTROL_OFFSET = 8'h31;
  localparam logic [7:0] UNLOCK_OFFSET = 8'h38;

  // arbitrary unlock value
  localparam logic [7:0] UNLOCK_CODE = 8'hA5;

  // field positions
  localparam int CL_SEL_LSB = 2;
  localparam int VCO_SEL_LSB = 0;
  localparam int PROG_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int BUSY_BIT = 2;

  // values after reset, plus the count limit and the idle read value
  localparam logic [6:0] RES_RESET = 7'h00;
  localparam logic [2:0] CAP_RESET = 3'h0;
  localparam logic [1:0] CL_SEL_RESET = 2'h2;
  localparam logic [1:0] VCO_SEL_RESET = 2'h1;
  localparam logic [7:0] CHECKSUM_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // capacitor step in picofarads
  localparam logic [5:0] CAP_PF_STEP = 6'h05;

  // settling times in microseconds and the clock rate
  localparam int CLK_MHZ = 10;
  localparam int VCO_WAIT0_US = 20;
  localparam int VCO_WAIT1_US = 400;
  localparam int VCO_WAIT2_US = 4000;
  localparam int VCO_WAIT3_US = 10000;
  localparam int CL_WAIT0_US = 150;
  localparam int CL_WAIT1_US = 300;
  localparam int CL_WAIT2_US = 500;
  localparam int CL_WAIT3_US = 2000;
  localparam int VCO_WAIT0_CYC = VCO_WAIT0_US * CLK_MHZ;
  localparam int VCO_WAIT1_CYC = VCO_WAIT1_US * CLK_MHZ;
  localparam int CL_WAIT0_CYC = CL_WAIT0_US * CLK_MHZ;
  localparam int CL_WAIT1_CYC = CL_WAIT1_US * CLK_MHZ;
  localparam int WAIT_CNT_W = 17;

  // resistance in ohms for the characterised codes, zero elsewhere
  function automatic logic [11:0] res_ohms(input logic [6:0] code);
    case (code)
      7'h00: res_ohms = 12'h012;
      7'h03: res_ohms = 12'h0CD;
      7'h08: res_ohms = 12'h356;
      7'h09: res_ohms = 12'h470;
      7'h0C: res_ohms = 12'h5FF;
      7'h11: res_ohms = 12'h790;
      7'h14: res_ohms = 12'h91F;
      default: res_ohms = 12'h000;
    endcase
  endfunction

endpackage

/* settle_timer.sv */
`timescale 1ns/10ps
module settle_timer #(
  parameter int VCO_WAIT2_CYC = pll_cal_regs_pkg::VCO_WAIT2_US * pll_cal_regs_pkg::CLK_MHZ,
  parameter int VCO_WAIT3_CYC = pll_cal_regs_pkg::VCO_WAIT3_US * pll_cal_regs_pkg::CLK_MHZ,
  parameter int CL_WAIT2_CYC = pll_cal_regs_pkg::CL_WAIT2_US * pll_cal_regs_pkg::CLK_MHZ,
  parameter int CL_WAIT3_CYC = pll_cal_regs_pkg::CL_WAIT3_US * pll_cal_regs_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic cal_start,
  input wire logic [1:0] vco_sel,
  input wire logic [1:0] cl_sel,
  // status
  output logic vco_settling,
  output logic loop_settling,
  output logic cal_done
);
  localparam int CW = pll_cal_regs_pkg::WAIT_CNT_W;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    VCO_WAIT = 3'b010,
    LOOP_WAIT = 3'b100
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [CW-1:0] cnt;
    logic done;
  } timer_t;

  timer_t st;
  timer_t next_st;
  logic [CW-1:0] vco_len;
  logic [CW-1:0] cl_len;

  always_comb begin
    case (vco_sel)
      2'h0: vco_len = CW'(pll_cal_regs_pkg::VCO_WAIT0_CYC - 1);
      2'h1: vco_len = CW'(pll_cal_regs_pkg::VCO_WAIT1_CYC - 1);
      2'h2: vco_len = CW'(VCO_WAIT2_CYC - 1);
      default: vco_len = CW'(VCO_WAIT3_CYC - 1);
    endcase
    case (cl_sel)
      2'h0: cl_len = CW'(pll_cal_regs_pkg::CL_WAIT0_CYC - 1);
      2'h1: cl_len = CW'(pll_cal_regs_pkg::CL_WAIT1_CYC - 1);
      2'h2: cl_len = CW'(CL_WAIT2_CYC - 1);
      default: cl_len = CW'(CL_WAIT3_CYC - 1);
    endcase
  end

  // oscillator wait first, then closed-loop wait
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.phase)
      IDLE: begin
        if (cal_start) begin
          next_st.phase = VCO_WAIT;
          next_st.cnt = vco_len;
        end
      end
      VCO_WAIT: begin
        if (st.cnt == '0) begin
          next_st.phase = LOOP_WAIT;
          next_st.cnt = cl_len;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      LOOP_WAIT: begin
        if (st.cnt == '0) begin
          next_st.phase = IDLE;
          next_st.done = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: next_st.phase = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{phase: IDLE, cnt: '0, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign vco_settling = st.phase[1];
  assign loop_settling = st.phase[2];
  assign cal_done = st.done;

  // helper count of closed-loop cycles, the wait is far too long for a plain delay
  logic [CW-1:0] loop_run;
  logic short_cl;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_run <= '0;
      short_cl <= 1'b0;
    end else begin
      loop_run <= loop_settling ? loop_run + 1'b1 : '0;
      if (vco_settling) begin
        short_cl <= (cl_sel == 2'h0);
      end
    end
  end

  sequence vco_then_loop;
    vco_settling ##1 (!vco_settling && loop_settling);
  endsequence

  sequence loop_then_done;
    loop_settling ##1 (!loop_settling && cal_done);
  endsequence

  chk_short_vco_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cal_start && st.phase == IDLE && vco_sel == 2'h0) |-> ##200 vco_then_loop)
    else $error("shortest oscillator wait not 200 cycles");

  chk_short_cl_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($fell(loop_settling) && short_cl) |->
      (cal_done && loop_run == CW'(pll_cal_regs_pkg::CL_WAIT0_CYC)))
    else $error("shortest closed-loop wait not 1500 cycles");

  chk_short_cl_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (loop_settling && short_cl && loop_run == CW'(pll_cal_regs_pkg::CL_WAIT0_CYC - 1)) |->
      loop_then_done)
    else $error("shortest closed-loop wait did not end on time");

  chk_phase_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(loop_settling) |-> $past(vco_settling))
    else $error("closed-loop wait without oscillator wait");

endmodule // settle_timer

/* nvm_model.sv */
`timescale 1ns/10ps
module nvm_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bench control
  input wire logic load_req,
  input wire logic slow,
  // device side
  input wire logic nvm_cycle_start,
  input wire logic [7:0] nvm_count_save,
  input wire logic nvm_count_save_en,
  output logic nvm_cycle_done,
  output logic nvm_load,
  output logic [7:0] nvm_count
);
  // survives reset, like the real array
  logic [7:0] mem_count = 8'h00;
  logic [7:0] wait_cnt;
  logic busy;
  // line is undriven outside a fetch, so show the inverse
  assign nvm_count = nvm_load ? mem_count : ~mem_count;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvm_load <= 1'b0;
      nvm_cycle_done <= 1'b0;
      busy <= 1'b0;
      wait_cnt <= 8'h00;
    end else begin
      nvm_load <= load_req;
      nvm_cycle_done <= 1'b0;
      if (nvm_cycle_start) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 8'h28 : 8'h03;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 8'h01;
        if (wait_cnt == 8'h01) begin
          busy <= 1'b0;
          nvm_cycle_done <= 1'b1;
        end
      end
      if (nvm_count_save_en) begin
        mem_count <= nvm_count_save;
      end
    end
  end
endmodule // nvm_model

/* test_pll_filter_cal_nvm_status_regs.sv */
`timescale 1ns/10ps
module test_pll_filter_cal_nvm_status_regs;
  localparam int V2 = 20, V3 = 30, C2 = 15, C3 = 25;
  localparam logic [7:0] A_RES = pll_cal_regs_pkg::RES_THREE_OFFSET;
  localparam logic [7:0] A_CAP = pll_cal_regs_pkg::CAP_THREE_OFFSET;
  localparam logic [7:0] A_CAL = pll_cal_regs_pkg::CAL_WAIT_OFFSET;
  localparam logic [7:0] A_SUM = pll_cal_regs_pkg::CHECKSUM_OFFSET;
  localparam logic [7:0] A_CNT = pll_cal_regs_pkg::PROG_COUNT_OFFSET;
  localparam logic [7:0] A_CTL = pll_cal_regs_pkg::NVM_CONTROL_OFFSET;
  localparam logic [7:0] A_UNL = pll_cal_regs_pkg::UNLOCK_OFFSET;
  localparam logic [7:0] KEY = pll_cal_regs_pkg::UNLOCK_CODE;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, nvm_count, nvm_count_save;
  logic [6:0] nvm_res_code = 7'h00, res_code;
  logic [2:0] nvm_cap_code = 3'h0, cap_code;
  logic [3:0] nvm_cal_wait = 4'h0;
  logic [7:0] nvm_checksum = 8'h00;
  logic cal_start = 1'b0, load_req = 1'b0, slow = 1'b0;
  logic reg_rd_valid, nvm_load, nvm_cycle_start, nvm_erase_req, nvm_prog_req;
  logic nvm_cycle_done, nvm_count_save_en, vco_settling, loop_settling, cal_done;
  logic [11:0] ohms;
  logic [5:0] cap_pf;
  logic [1:0] cl_sel, osc_sel;
  logic [7:0] exp_q[$];
  logic [6:0] codes[7] = '{7'h00, 7'h03, 7'h08, 7'h09, 7'h0C, 7'h11, 7'h14};
  logic [11:0] ohm_tab[7] = '{12'h012, 12'h0CD, 12'h356, 12'h470, 12'h5FF, 12'h790, 12'h91F};
  int err_count = 0, total_checks = 0;
  logic [31:0] seed = 32'hE022D188;
  always #50 sys_clk = ~sys_clk;
  pll_filter_cal_nvm_status_regs #(.VCO_WAIT2_CYC(V2), .VCO_WAIT3_CYC(V3), .CL_WAIT2_CYC(C2),
      .CL_WAIT3_CYC(C3)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .nvm_load(nvm_load),
    .nvm_res_code(nvm_res_code), .nvm_cap_code(nvm_cap_code), .nvm_cal_wait(nvm_cal_wait),
    .nvm_checksum(nvm_checksum), .nvm_count(nvm_count), .nvm_cycle_start(nvm_cycle_start),
    .nvm_erase_req(nvm_erase_req), .nvm_prog_req(nvm_prog_req),
    .nvm_cycle_done(nvm_cycle_done), .nvm_count_save(nvm_count_save),
    .nvm_count_save_en(nvm_count_save_en), .cal_start(cal_start), .vco_settling(vco_settling),
    .loop_settling(loop_settling), .cal_done(cal_done), .filter_res_three_code(res_code),
    .filter_res_ohms(ohms), .filter_cap_three_code(cap_code), .filter_cap_pf(cap_pf),
    .closed_loop_settle_select(cl_sel), .oscillator_settle_select(osc_sel));
  nvm_model mdl (.sys_clk(sys_clk), .sys_rst(sys_rst), .load_req(load_req), .slow(slow),
    .nvm_cycle_start(nvm_cycle_start), .nvm_count_save(nvm_count_save),
    .nvm_count_save_en(nvm_count_save_en), .nvm_cycle_done(nvm_cycle_done),
    .nvm_load(nvm_load), .nvm_count(nvm_count));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge sys_clk);
    #1;
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #1;
    exp_q.push_back(e);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd_en = 1'b0;
  endtask
  // read answers are matched in order against the noted expectations
  always @(posedge sys_clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("rd_extra", 16'h0000, 16'h0001);
      end else begin
        chk("rd_data", exp_q.pop_front(), reg_rd_data);
      end
    end
  end
  task automatic load();
    @(posedge sys_clk);
    #1;
    load_req = 1'b1;
    @(posedge sys_clk);
    #1;
    load_req = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic nvm_op(input logic [7:0] d, input logic [7:0] key, input logic stray,
      input logic [7:0] e, input logic go);
    logic seen;
    logic [1:0] req;
    logic [7:0] sv;
    logic fin;
    seen = 1'b0;
    fin = 1'b0;
    req = 2'h0;
    sv = 8'h00;
    if (key != 8'h00) wr(A_UNL, key);
    if (stray) wr(8'h55, 8'h00);
    wr(A_CTL, d);
    for (int i = 0; i < 100; i++) begin
      if (nvm_cycle_start === 1'b1) begin
        seen = 1'b1;
        req = {nvm_erase_req, nvm_prog_req};
        rd(A_CTL, 8'h04);
      end
      if (nvm_count_save_en === 1'b1) begin
        sv = nvm_count_save;
        fin = 1'b1;
        break;
      end
      @(posedge sys_clk);
      #1;
    end
    if (go && !fin) begin
      err_count++;
      $display("CHECK FAILED count_save_en expected 1 seen 0");
      final_report();
    end
    chk("cycle_start", go, seen);
    if (go) begin
      chk("cycle_req", d[1:0], req);
      chk("count_save", e, sv);
      rd(A_CNT, e);
    end
  endtask
  task automatic cal(input logic [1:0] o, input logic [1:0] c, input int ev, input int el);
    int nv;
    int nl;
    nv = 0;
    nl = 0;
    wr(A_CAL, {4'h0, c, o});
    chk("osc_sel", o, osc_sel);
    chk("cl_sel", c, cl_sel);
    @(posedge sys_clk);
    #1;
    cal_start = 1'b1;
    @(posedge sys_clk);
    #1;
    cal_start = 1'b0;
    for (int i = 0; i <= 30000; i++) begin
      if (cal_done === 1'b1) break;
      if (i == 30000) begin
        err_count++;
        $display("CHECK FAILED cal_done expected 1 seen 0");
        final_report();
      end
      if (vco_settling === 1'b1) nv++;
      if (loop_settling === 1'b1) nl++;
      @(posedge sys_clk);
      #1;
    end
    chk("vco_cycles", ev, nv);
    chk("loop_cycles", el, nl);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    chk("res_ohms", 16'h0012, ohms);
    rd(A_RES, 8'h00);
    rd(A_CAP, 8'h00);
    rd(A_CAL, 8'h09);
    rd(A_SUM, 8'h00);
    rd(A_CNT, 8'h00);
    rd(8'h55, 8'h00);
    rd(A_CTL, 8'h00);
    wr(A_SUM, 8'hFF);
    wr(A_CNT, 8'hFF);
    rd(A_SUM, 8'h00);
    rd(A_CNT, 8'h00);
    wr(A_RES, 8'hFF);
    rd(A_RES, 8'h7F);
    wr(A_CAL, 8'hFF);
    rd(A_CAL, 8'h0F);
    for (int k = 0; k < 7; k++) begin
      wr(A_RES, {1'b0, codes[k]});
      chk("res_ohms", ohm_tab[k], ohms);
    end
    for (int k = 0; k < 8; k++) begin
      wr(A_CAP, {5'h1F, k[2:0]});
      chk("cap_pf", k * 5, cap_pf);
      chk("cap_code", k[2:0], cap_code);
      rd(A_CAP, {5'h00, k[2:0]});
    end
    repeat (8) begin
      seed = lfsr(seed);
      wr(A_RES, seed[7:0]);
      chk("res_code", seed[6:0], res_code);
      rd(A_RES, {1'b0, seed[6:0]});
    end
    nvm_res_code = 7'h14;
    nvm_cap_code = 3'h5;
    nvm_cal_wait = 4'h6;
    nvm_checksum = 8'h3C;
    load();
    chk("res_ohms", 16'h091F, ohms);
    chk("cap_pf", 16'h0019, cap_pf);
    rd(A_RES, 8'h14);
    rd(A_CAL, 8'h06);
    rd(A_SUM, 8'h3C);
    rd(A_CNT, 8'h00);
    nvm_op(8'h01, KEY, 1'b0, 8'h01, 1'b1);
    slow = 1'b1;
    nvm_op(8'h02, KEY, 1'b0, 8'h02, 1'b1);
    nvm_op(8'h03, KEY, 1'b0, 8'h03, 1'b1);
    nvm_op(8'h01, 8'h00, 1'b0, 8'h00, 1'b0);
    nvm_op(8'h01, 8'h5A, 1'b0, 8'h00, 1'b0);
    nvm_op(8'h02, KEY, 1'b1, 8'h00, 1'b0);
    mdl.mem_count = 8'hFE;
    load();
    rd(A_CNT, 8'hFE);
    nvm_op(8'h01, KEY, 1'b0, 8'hFF, 1'b1);
    nvm_op(8'h03, KEY, 1'b0, 8'hFF, 1'b1);
    cal(2'h0, 2'h0, pll_cal_regs_pkg::VCO_WAIT0_CYC, pll_cal_regs_pkg::CL_WAIT0_CYC);
    cal(2'h1, 2'h1, pll_cal_regs_pkg::VCO_WAIT1_CYC, pll_cal_regs_pkg::CL_WAIT1_CYC);
    cal(2'h2, 2'h2, V2, C2);
    cal(2'h3, 2'h3, V3, C3);
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    rd(A_CAL, 8'h09);
    load();
    rd(A_CNT, 8'hFF);
    repeat (3) @(posedge sys_clk);
    chk("rd_pending", 16'h0000, exp_q.size());
    final_report();
  end
endmodule // test_pll_filter_cal_nvm_status_regs
